// ==== scp_serial_config_port.sv ====
// Purpose: serial configuration port, device side
// Assumes: serial clock, select and data sampled by SYS_CLK through two flops
// Notes: read-back lags the serial clock fall by up to three system cycles
`timescale 1ns/10ps
`default_nettype none
module scp_serial_config_port (
    input wire logic SYS_CLK, // system clock, 20 MHz
    input wire logic NRST, // synchronous reset, active low
    input wire logic SCK, // serial shift clock from host
    input wire logic CS_N, // frame select, active low
    input wire logic SDIO_I, // serial data line, input side
    output logic SDIO_O, // serial data line, driven value
    output logic SDIO_OE, // serial data line, drive enable
    output logic SDO, // separate read-back output, 4-wire mode
    input wire logic FOUR_WIRE, // high selects separate read-back output
    output logic WR_STROBE, // one-cycle pulse per register write
    output logic [14:0] WR_ADDR, // address of last write
    output logic [7:0] WR_DATA // data of last write
);
    scp_mem_if bus ();

    scp_regmem u_mem (
        .clk(SYS_CLK),
        .nrst(NRST),
        .bus(bus)
    );

    // input synchronisers
    logic sck_m_r, sck_s_r, sck_d_r;
    logic cs_m_r, cs_s_r, cs_d_r;
    logic din_m_r, din_s_r;
    logic fw_m_r, fw_s_r;
    logic sck_rise, sck_fall, cs_rise;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            sck_m_r <= 1'b0;
            sck_s_r <= 1'b0;
            sck_d_r <= 1'b0;
            cs_m_r <= 1'b1;
            cs_s_r <= 1'b1;
            cs_d_r <= 1'b1;
            din_m_r <= 1'b0;
            din_s_r <= 1'b0;
            fw_m_r <= 1'b0;
            fw_s_r <= 1'b0;
        end else begin
            sck_m_r <= SCK;
            sck_s_r <= sck_m_r;
            sck_d_r <= sck_s_r;
            cs_m_r <= CS_N;
            cs_s_r <= cs_m_r;
            cs_d_r <= cs_s_r;
            din_m_r <= SDIO_I;
            din_s_r <= din_m_r;
            fw_m_r <= FOUR_WIRE;
            fw_s_r <= fw_m_r;
        end
    end

    assign sck_rise = sck_s_r && !sck_d_r;
    assign sck_fall = !sck_s_r && sck_d_r;
    assign cs_rise = cs_s_r && !cs_d_r;

    // frame control
    scp_pkg::scp_state_t state_r, state_nxt;
    logic [scp_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [scp_pkg::FRAME_W-1:0] sh_r, sh_nxt;
    logic [scp_pkg::DATA_BITS-1:0] rd_r, rd_nxt;
    logic out_r, out_nxt, oe_r, oe_nxt, sdo_r, sdo_nxt;
    logic re_r, re_nxt, ld_r, ld_nxt, we_r, we_nxt;
    logic [scp_pkg::ADDR_BITS-1:0] raddr_r, raddr_nxt, waddr_r, waddr_nxt;
    logic [scp_pkg::DATA_BITS-1:0] wdata_r, wdata_nxt;
    logic [scp_pkg::DATA_BITS-1:0] rd_src;

    // store data bypass: the first fall may meet the load cycle
    assign rd_src = ld_r ? bus.rdata : rd_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        out_nxt = out_r;
        oe_nxt = oe_r;
        sdo_nxt = sdo_r;
        re_nxt = 1'b0;
        ld_nxt = re_r;
        raddr_nxt = raddr_r;
        we_nxt = 1'b0;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        if (ld_r) begin
            rd_nxt = bus.rdata;
        end
        if (cs_s_r) begin
            state_nxt = scp_pkg::SCP_IDLE;
            cnt_nxt = '0;
            oe_nxt = 1'b0;
            out_nxt = 1'b0;
            sdo_nxt = 1'b0;
            // store only a complete write frame
            if (cs_rise && state_r == scp_pkg::SCP_WRITE && cnt_r == scp_pkg::FRAME_BITS) begin
                we_nxt = 1'b1;
                waddr_nxt = sh_r[scp_pkg::ADDR_MSB:scp_pkg::ADDR_LSB];
                wdata_nxt = sh_r[scp_pkg::DATA_MSB:0];
            end
        end else begin
            if (sck_rise && cnt_r != scp_pkg::FRAME_BITS) begin
                sh_nxt = {sh_r[scp_pkg::FRAME_W-2:0], din_s_r};
                cnt_nxt = cnt_r + 5'h01;
            end
            case (state_r)
                scp_pkg::SCP_IDLE: begin
                    state_nxt = scp_pkg::SCP_HEAD;
                end
                scp_pkg::SCP_HEAD: begin
                    // decide on the last address rise so store data is ready for the fall
                    if (sck_rise && cnt_r == scp_pkg::HEAD_BITS - 5'h01) begin
                        if (sh_r[scp_pkg::HEAD_BITS-2] == scp_pkg::RW_READ) begin
                            state_nxt = scp_pkg::SCP_READ;
                            re_nxt = 1'b1;
                            raddr_nxt = {sh_r[scp_pkg::ADDR_BITS-2:0], din_s_r};
                        end else begin
                            state_nxt = scp_pkg::SCP_WRITE;
                        end
                    end
                end
                scp_pkg::SCP_WRITE: begin
                    state_nxt = scp_pkg::SCP_WRITE;
                end
                scp_pkg::SCP_READ: begin
                    if (sck_fall) begin
                        rd_nxt = {rd_src[scp_pkg::DATA_BITS-2:0], 1'b0};
                        if (fw_s_r) begin
                            sdo_nxt = rd_src[scp_pkg::DATA_BITS-1];
                        end else begin
                            out_nxt = rd_src[scp_pkg::DATA_BITS-1];
                            oe_nxt = 1'b1;
                        end
                    end
                end
                default: begin
                    state_nxt = scp_pkg::SCP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_r <= scp_pkg::SCP_IDLE;
            cnt_r <= '0;
            sh_r <= '0;
            rd_r <= '0;
            out_r <= 1'b0;
            oe_r <= 1'b0;
            sdo_r <= 1'b0;
            re_r <= 1'b0;
            ld_r <= 1'b0;
            raddr_r <= '0;
            we_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            sdo_r <= sdo_nxt;
            re_r <= re_nxt;
            ld_r <= ld_nxt;
            raddr_r <= raddr_nxt;
            we_r <= we_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    assign bus.we = we_r;
    assign bus.waddr = waddr_r;
    assign bus.wdata = wdata_r;
    assign bus.re = re_r;
    assign bus.raddr = raddr_r;
    assign SDIO_O = out_r;
    assign SDIO_OE = oe_r;
    assign SDO = sdo_r;
    assign WR_STROBE = we_r;
    assign WR_ADDR = waddr_r;
    assign WR_DATA = wdata_r;

    // checks
    localparam int DV_MAX = scp_pkg::DV_CYC;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    property p_shift;
        (!cs_s_r && sck_rise && cnt_r != scp_pkg::FRAME_BITS)
            |=> (sh_r[0] == $past(din_s_r)) && (cnt_r == $past(cnt_r) + 5'h01);
    endproperty
    a_shift: assert property (p_shift) else $error("bit not shifted in");

    property p_store;
        (cs_rise && state_r == scp_pkg::SCP_WRITE && cnt_r == scp_pkg::FRAME_BITS)
            |=> we_r ##1 (!we_r && WR_DATA == $past(sh_r[7:0], 2));
    endproperty
    a_store: assert property (p_store) else $error("write frame not stored");

    property p_rw;
        (!cs_s_r && state_r == scp_pkg::SCP_HEAD && sck_rise
            && cnt_r == scp_pkg::HEAD_BITS - 5'h01)
            |=> (state_r == scp_pkg::SCP_READ) == $past(sh_r[14]);
    endproperty
    a_rw: assert property (p_rw) else $error("flag did not pick operation");

    property p_four;
        (!cs_s_r && state_r == scp_pkg::SCP_READ && sck_fall && fw_s_r)
            |=> (SDO == $past(rd_src[7])) && !SDIO_OE;
    endproperty
    a_four: assert property (p_four) else $error("4-wire bit wrong");

    property p_dv;
        (!cs_s_r && state_r == scp_pkg::SCP_READ && sck_fall && !fw_s_r)
            |=> (SDIO_OE && SDIO_O == $past(rd_src[7]));
    endproperty
    a_dv: assert property (p_dv) else $error("read bit late or wrong");

    property p_frame;
        we_r |-> $past(cnt_r) == scp_pkg::FRAME_BITS && $past(sh_r[23]) == scp_pkg::RW_WRITE;
    endproperty
    a_frame: assert property (p_frame) else $error("write from short or read frame");

    property p_dv_bound;
        (!cs_s_r && state_r == scp_pkg::SCP_READ && sck_fall && !fw_s_r)
            |-> ##[1:DV_MAX] SDIO_OE;
    endproperty
    a_dv_bound: assert property (p_dv_bound) else $error("read bit not driven in time");

    c_write: cover property (we_r);
    c_read3: cover property (SDIO_OE && state_r == scp_pkg::SCP_READ);
    c_read4: cover property (fw_s_r && state_r == scp_pkg::SCP_READ && sck_fall);
endmodule
`default_nettype wire

// ==== scp_pkg.sv ====
// Purpose: shared constants and types of the serial configuration port
// Assumes: 20 MHz system clock, 24-bit frames
// Notes: register store covers the low address window only
package scp_pkg;
    localparam int DATA_BITS = 8;
    localparam int ADDR_BITS = 15;
    localparam int FRAME_W = 24;
    localparam int CNT_W = 5;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] HEAD_BITS = 5'h10;
    localparam int RW_POS = 23;
    localparam int ADDR_MSB = 22;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam int SYS_PERIOD_NS = 50;
    localparam int T_DV_NS = 120;
    // longest time rounds down, at least one cycle
    localparam int DV_CYC = (T_DV_NS / SYS_PERIOD_NS) < 1 ? 1 : (T_DV_NS / SYS_PERIOD_NS);
    typedef enum logic [1:0] {SCP_IDLE, SCP_HEAD, SCP_WRITE, SCP_READ} scp_state_t;
endpackage

// ==== scp_mem_if.sv ====
// Purpose: link between frame control and register store
// Assumes: single clock domain
// Notes: read data registered, valid one cycle after re
`timescale 1ns/10ps
`default_nettype none
interface scp_mem_if;
    logic we;
    logic [scp_pkg::ADDR_BITS-1:0] waddr;
    logic [scp_pkg::DATA_BITS-1:0] wdata;
    logic re;
    logic [scp_pkg::ADDR_BITS-1:0] raddr;
    logic [scp_pkg::DATA_BITS-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface
`default_nettype wire

// ==== scp_regmem.sv ====
// Purpose: byte-wide configuration register store
// Assumes: addresses outside the window are not stored
// Notes: unstored addresses read back as zero
`timescale 1ns/10ps
`default_nettype none
module scp_regmem (
    input wire logic clk, // system clock
    input wire logic nrst, // synchronous reset, active low
    scp_mem_if.mem bus // store port
);
    logic [scp_pkg::DATA_BITS-1:0] mem [scp_pkg::MEM_DEPTH];
    logic [scp_pkg::DATA_BITS-1:0] rdata_r;
    logic [scp_pkg::DATA_BITS-1:0] rdata_nxt;
    logic w_in, r_in;

    assign w_in = bus.waddr[scp_pkg::ADDR_BITS-1:scp_pkg::MEM_AW] == '0;
    assign r_in = bus.raddr[scp_pkg::ADDR_BITS-1:scp_pkg::MEM_AW] == '0;
    assign bus.rdata = rdata_r;

    always_comb begin
        rdata_nxt = rdata_r;
        if (bus.re) begin
            rdata_nxt = r_in ? mem[bus.raddr[scp_pkg::MEM_AW-1:0]] : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (bus.we && w_in) begin
            mem[bus.waddr[scp_pkg::MEM_AW-1:0]] <= bus.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== scp_host_model.sv ====
// Purpose: host controller model driving the serial programming bus
// Assumes: SCK low 250 ns, high 150 ns; frames start off the system clock phase
// Notes: released data line shows the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module scp_host_model (
    output logic SCK, // serial clock, still between frames
    output logic CS_N, // frame select, active low
    output logic SDIO_I, // resolved data line level
    input wire logic SDIO_O, // device drive value
    input wire logic SDIO_OE, // device drive enable
    input wire logic SDO, // separate read-back output
    input wire logic FOUR_WIRE // read-back taken from SDO
);
    logic drv = 1'b0;
    logic val = 1'b0;
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
    end
    assign SDIO_I = SDIO_OE ? SDIO_O : (drv ? val : ~val);

    task automatic frame(input logic rw, input logic [14:0] addr, input logic [7:0] data,
                         input int nbits, output logic [7:0] rd);
        logic [23:0] word;
        word = {rw, addr, data};
        rd = 8'h00;
        CS_N = 1'b0;
        #107;
        for (int i = 0; i < nbits; i++) begin
            drv = (rw == scp_pkg::RW_WRITE) || (i < 16);
            val = word[23 - i];
            #250 SCK = 1'b1;
            if (i >= 16) rd[23 - i] = FOUR_WIRE ? SDO : SDIO_I;
            #150 SCK = 1'b0;
        end
        #100 CS_N = 1'b1;
        drv = 1'b0;
        #300;
    endtask
endmodule
`default_nettype wire

// ==== scp_serial_config_port_tb.sv ====
// Purpose: self-checking bench of the serial configuration port
// Assumes: host model supplies the link; writes noted in a queue
// Notes: store holds addresses 0..255, others read back zero
`timescale 1ns/10ps
`default_nettype none
module scp_serial_config_port_tb;
    logic SYS_CLK, NRST, FOUR_WIRE, SCK, CS_N, SDIO_I, SDIO_O, SDIO_OE, SDO, WR_STROBE;
    logic [14:0] WR_ADDR;
    logic [7:0] WR_DATA;
    logic [7:0] rd;
    logic [22:0] exp_q[$];
    logic [14:0] addr_a[6];
    logic [7:0] dat_a[6];
    int bad_count = 0;
    int checks_done = 0;
    int seed = 92014;

    scp_serial_config_port DUT (.SYS_CLK(SYS_CLK), .NRST(NRST), .SCK(SCK), .CS_N(CS_N),
        .SDIO_I(SDIO_I), .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE), .SDO(SDO),
        .FOUR_WIRE(FOUR_WIRE), .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA));
    scp_host_model host (.SCK(SCK), .CS_N(CS_N), .SDIO_I(SDIO_I), .SDIO_O(SDIO_O),
        .SDIO_OE(SDIO_OE), .SDO(SDO), .FOUR_WIRE(FOUR_WIRE));

    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    task automatic check(input logic [22:0] seen, input logic [22:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        exp_q.push_back({a, d});
        host.frame(scp_pkg::RW_WRITE, a, d, 24, rd);
    endtask

    task automatic rdchk(input logic fw, input logic [14:0] a, input logic [7:0] e);
        @(negedge SYS_CLK) FOUR_WIRE = fw;
        host.frame(scp_pkg::RW_READ, a, 8'h00, 24, rd);
        check({15'h0000, rd}, {15'h0000, e});
    endtask

    // every strobe must match the oldest noted write
    always @(negedge SYS_CLK) begin
        if (WR_STROBE === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({22'h000000, WR_STROBE}, 23'h000000);
            end else begin
                check({WR_ADDR, WR_DATA}, exp_q.pop_front());
            end
        end
    end

    initial begin
        #1_000_000;
        bad_count++;
        conclude();
    end

    initial begin
        NRST = 1'b0;
        FOUR_WIRE = 1'b0;
        repeat (5) @(negedge SYS_CLK);
        NRST = 1'b1;
        repeat (4) @(negedge SYS_CLK);
        for (int k = 0; k < 6; k++) begin
            addr_a[k] = {7'h00, 3'(k), 5'($random(seed))};
            dat_a[k] = 8'($random(seed));
            wr(addr_a[k], dat_a[k]);
        end
        $display("test back-to-back writes done");
        for (int k = 0; k < 6; k++) begin
            rdchk(1'b0, addr_a[k], dat_a[k]);
        end
        for (int k = 0; k < 6; k++) begin
            rdchk(1'b1, addr_a[k], dat_a[k]);
        end
        $display("test three- and four-wire reads done");
        wr(15'h00FF, 8'h5A);
        wr(15'h0100, 8'hA5);
        rdchk(1'b0, 15'h00FF, 8'h5A);
        rdchk(1'b1, 15'h0100, 8'h00);
        $display("test store boundary done");
        host.frame(scp_pkg::RW_WRITE, 15'h00FF, 8'h00, 23, rd);
        rdchk(1'b0, 15'h00FF, 8'h5A);
        $display("test short frame done");
        repeat (10) @(negedge SYS_CLK);
        check(23'(exp_q.size()), 23'h000000);
        conclude();
    end
endmodule
`default_nettype wire
